// ==== rtl/lane_map_pkg.sv ====
// Constants, layouts and carrier types for the lane sample mapper
package lane_map_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int MODE_W       = 7;
  localparam int SAMP15_W     = 15;
  localparam int SAMP12_W     = 12;
  localparam int LANE_W       = 16;
  localparam int LANES_PER_CH = 8;
  localparam int SAMP_PER_CH  = 4;
  localparam int BYP_SAMPLES  = 16;
  localparam int BYP_GROUPS   = 2;
  localparam int BYP_PER_TRI  = 4;
  localparam int TRI_LANES    = 3;
  localparam int PAIR_D8      = 2;
  localparam int QUAD_D16     = 4;

  // ----------------------------------------------------------------
  // Link mode numbers
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_11 = 7'h0b;
  localparam logic [MODE_W-1:0] MODE_47 = 7'h2f;
  localparam logic [MODE_W-1:0] MODE_12 = 7'h0c;
  localparam logic [MODE_W-1:0] MODE_53 = 7'h35;
  localparam logic [MODE_W-1:0] MODE_13 = 7'h0d;
  localparam logic [MODE_W-1:0] MODE_39 = 7'h27;
  localparam logic [MODE_W-1:0] MODE_56 = 7'h38;
  localparam logic [MODE_W-1:0] MODE_59 = 7'h3b;
  localparam logic [MODE_W-1:0] MODE_66 = 7'h42;
  localparam logic [MODE_W-1:0] MODE_68 = 7'h44;
  localparam logic [MODE_W-1:0] MODE_14 = 7'h0e;
  localparam logic [MODE_W-1:0] MODE_49 = 7'h31;
  localparam logic [MODE_W-1:0] MODE_57 = 7'h39;
  localparam logic [MODE_W-1:0] MODE_60 = 7'h3c;
  localparam logic [MODE_W-1:0] MODE_67 = 7'h43;
  localparam logic [MODE_W-1:0] MODE_15 = 7'h0f;
  localparam logic [MODE_W-1:0] MODE_55 = 7'h37;
  localparam logic [MODE_W-1:0] MODE_58 = 7'h3a;
  localparam logic [MODE_W-1:0] MODE_16 = 7'h10;
  localparam logic [MODE_W-1:0] MODE_19 = 7'h13;
  localparam logic [MODE_W-1:0] MODE_42 = 7'h2a;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LAY_NONE  = 3'h0,
    LAY_D4_8  = 3'h1,
    LAY_D4_16 = 3'h2,
    LAY_D8_2  = 3'h3,
    LAY_D8_4  = 3'h4,
    LAY_D8_8  = 3'h5,
    LAY_D8_16 = 3'h6,
    LAY_BYP12 = 3'h7
  } layout_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_FIRST  = 3'h2,
    ST_SECOND = 3'h4
  } map_state_t;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef logic [SAMP15_W-1:0] samp15_t;
  typedef logic [SAMP12_W-1:0] samp12_t;
  typedef logic [LANE_W-1:0]   lane_word_t;

  typedef struct packed {
    samp15_t [SAMP_PER_CH-1:0] inphase;
    samp15_t [SAMP_PER_CH-1:0] quad;
    logic    [SAMP_PER_CH-1:0] inphase_flag;
    logic    [SAMP_PER_CH-1:0] quad_flag;
  } chan_frame_t;

  typedef struct packed {
    logic    [MODE_W-1:0]      link_mode_number;
    chan_frame_t               chan_a;
    chan_frame_t               chan_b;
    samp12_t [BYP_SAMPLES-1:0] bypass;
  } in_frame_t;

  typedef struct packed {
    lane_word_t [LANES_PER_CH-1:0] lane_a;
    lane_word_t [LANES_PER_CH-1:0] lane_b;
  } lanes_t;

  typedef struct packed {
    lanes_t  lanes;
    logic    second_pair;
    logic    mode_err;
    layout_t layout;
  } out_word_t;

endpackage

// ==== rtl/lane_skid_buffer.sv ====
// Two-entry buffer with valid and ready on both sides, registered outputs
`timescale 1ns/1ps
module lane_skid_buffer
  import lane_map_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Filling side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Draining side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  logic         tail_v_r;
  logic [W-1:0] tail_r;
  logic         push;
  logic         pop;

  // Ready only while the spare slot is free, so a stall never drops a word
  assign o_ready = ~tail_v_r;
  assign push    = i_valid & ~tail_v_r;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_valid  <= 1'b0;
      tail_v_r <= 1'b0;
      o_data   <= '0;
      tail_r   <= '0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (!o_valid)
          begin
            o_data  <= i_data;
            o_valid <= 1'b1;
          end
          else
          begin
            tail_r   <= i_data;
            tail_v_r <= 1'b1;
          end
        end
        2'b01:
        begin
          if (tail_v_r)
          begin
            o_data   <= tail_r;
            tail_v_r <= 1'b0;
          end
          else
          begin
            o_valid <= 1'b0;
          end
        end
        2'b11:
        begin
          o_data <= i_data;
        end
        default:
        begin
          o_valid <= o_valid;
        end
      endcase
    end
  end

endmodule

// ==== rtl/jesd_lane_sample_mapper.sv ====
// Transport-layer mapper: converter samples onto sixteen lane words per frame
// ----------------------------------------------------------------
// What this block does
// - Mode 11: a0,a1 carry in-phase 0,1; a2,a3 quadrature 0,1; B likewise.
// - Mode 47 places samples and flags exactly like mode 11.
// - Mode 12: a0-a3 in-phase 0-3, a4-a7 quadrature 0-3; B likewise.
// - Mode 53 places samples and flags exactly like mode 12.
// - Mode 13: four-octet lane frame, in-phase octets 0-1, quadrature 2-3.
// - Modes 39, 56, 59, 66, 68 use the mode 13 placement.
// - Mode 14: a0 in-phase, a1 quadrature, b0/b1 likewise, one per frame.
// - Modes 49, 57, 60, 67 use the mode 14 placement.
// - Mode 15: two in-phase then two quadrature per channel on four lanes.
// - Modes 55 and 58 use the mode 15 placement.
// - Mode 16: four in-phase then four quadrature per channel, eight lanes.
// - Mode 19: four 12-bit samples packed MSB first into three lane words.
// - Mode 19: A lanes carry even samples, B lanes odd, two triplets each.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module jesd_lane_sample_mapper
  import lane_map_pkg::*;
(
  // Clock and reset
  input  wire logic      I_CORE_CLK,
  input  wire logic      I_RST_N,
  // Sample frames from the decimation or bypass path
  input  wire logic      I_IN_VALID,
  input  wire in_frame_t I_FRAME,
  output logic           O_IN_READY,
  // Lane words toward the link layer
  output logic           O_LANES_VALID,
  output out_word_t      O_WORD,
  input  wire logic      I_LANES_READY
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  function automatic layout_t decode_mode(input logic [MODE_W-1:0] m);
    layout_t lay;
    lay = LAY_NONE;
    case (m)
      MODE_11, MODE_47: lay = LAY_D4_8;
      MODE_12, MODE_53: lay = LAY_D4_16;
      MODE_13, MODE_39, MODE_56, MODE_59, MODE_66, MODE_68: lay = LAY_D8_2;
      MODE_14, MODE_49, MODE_57, MODE_60, MODE_67: lay = LAY_D8_4;
      MODE_15, MODE_55, MODE_58: lay = LAY_D8_8;
      MODE_16: lay = LAY_D8_16;
      MODE_19, MODE_42: lay = LAY_BYP12;
      default: lay = LAY_NONE;
    endcase
    return lay;
  endfunction

  // sample high, flag in bit 0
  function automatic lane_word_t word15(input samp15_t s, input logic flag);
    return {s, flag};
  endfunction

  // One channel's eight lane words for the decimated layouts
  function automatic lane_word_t [LANES_PER_CH-1:0] place_chan(
    input chan_frame_t c,
    input layout_t     lay,
    input logic        second
  );
    lane_word_t [LANES_PER_CH-1:0] w;
    w = '0;
    case (lay)
      LAY_D4_8, LAY_D8_8:
      begin
        for (int k = 0; k < PAIR_D8; k++)
        begin
          w[k]           = word15(c.inphase[k], c.inphase_flag[k]);
          w[k + PAIR_D8] = word15(c.quad[k], c.quad_flag[k]);
        end
      end
      LAY_D4_16, LAY_D8_16:
      begin
        for (int k = 0; k < QUAD_D16; k++)
        begin
          w[k]            = word15(c.inphase[k], c.inphase_flag[k]);
          w[k + QUAD_D16] = word15(c.quad[k], c.quad_flag[k]);
        end
      end
      LAY_D8_4:
      begin
        // one lane each for in-phase and quadrature
        w[0] = word15(c.inphase[0], c.inphase_flag[0]);
        w[1] = word15(c.quad[0], c.quad_flag[0]);
      end
      LAY_D8_2:
      begin
        // octets 0-1 in-phase, octets 2-3 quadrature
        if (second)
        begin
          w[0] = word15(c.quad[0], c.quad_flag[0]);
        end
        else
        begin
          w[0] = word15(c.inphase[0], c.inphase_flag[0]);
        end
      end
      default:
      begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // four samples, MSB first, into three lane words
  function automatic lane_word_t [TRI_LANES-1:0] pack_tri(
    input samp12_t s0,
    input samp12_t s1,
    input samp12_t s2,
    input samp12_t s3
  );
    lane_word_t [TRI_LANES-1:0] t;
    t = {s0, s1, s2, s3};
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Frame hold and sequencing
  // ----------------------------------------------------------------
  map_state_t state_r;
  map_state_t state_nxt;
  in_frame_t  hold_r;
  layout_t    layout_r;
  logic       buf_ready;
  logic       buf_push;
  logic       accept;
  out_word_t  word_nxt;
  lanes_t     lanes_nxt;
  lane_word_t [TRI_LANES-1:0] tri_even;
  lane_word_t [TRI_LANES-1:0] tri_odd;

  // One frame in flight; a two-lane frame needs two words, so input stalls
  assign accept   = I_IN_VALID & O_IN_READY;
  assign buf_push = (state_r == ST_FIRST) | (state_r == ST_SECOND);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_nxt = ST_FIRST;
        end
      end
      ST_FIRST:
      begin
        if (buf_ready)
        begin
          // second octet pair follows for two-lane layouts
          state_nxt = (layout_r == LAY_D8_2) ? ST_SECOND : ST_IDLE;
        end
      end
      ST_SECOND:
      begin
        if (buf_ready)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Ready comes from a flop, valid only while the hold stage is empty
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      O_IN_READY <= 1'b0;
    end
    else
    begin
      O_IN_READY <= (state_nxt == ST_IDLE);
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      hold_r   <= '0;
      layout_r <= LAY_NONE;
    end
    else if (accept)
    begin
      hold_r   <= I_FRAME;
      layout_r <= decode_mode(I_FRAME.link_mode_number);
    end
  end

  // ----------------------------------------------------------------
  // Lane placement
  // ----------------------------------------------------------------
  always_comb
  begin
    lanes_nxt = '0;
    tri_even  = '0;
    tri_odd   = '0;
    if (layout_r == LAY_BYP12)
    begin
      // even samples on A lanes, odd on B, one triplet per eight samples
      for (int g = 0; g < BYP_GROUPS; g++)
      begin
        tri_even = pack_tri(
          hold_r.bypass[2 * g * BYP_PER_TRI],
          hold_r.bypass[2 * g * BYP_PER_TRI + 2],
          hold_r.bypass[2 * g * BYP_PER_TRI + 4],
          hold_r.bypass[2 * g * BYP_PER_TRI + 6]);
        tri_odd = pack_tri(
          hold_r.bypass[2 * g * BYP_PER_TRI + 1],
          hold_r.bypass[2 * g * BYP_PER_TRI + 3],
          hold_r.bypass[2 * g * BYP_PER_TRI + 5],
          hold_r.bypass[2 * g * BYP_PER_TRI + 7]);
        for (int j = 0; j < TRI_LANES; j++)
        begin
          lanes_nxt.lane_a[g * TRI_LANES + j] = tri_even[TRI_LANES - 1 - j];
          lanes_nxt.lane_b[g * TRI_LANES + j] = tri_odd[TRI_LANES - 1 - j];
        end
      end
    end
    else
    begin
      lanes_nxt.lane_a = place_chan(hold_r.chan_a, layout_r, state_r == ST_SECOND);
      lanes_nxt.lane_b = place_chan(hold_r.chan_b, layout_r, state_r == ST_SECOND);
    end
  end

  always_comb
  begin
    word_nxt             = '0;
    word_nxt.lanes       = lanes_nxt;
    word_nxt.second_pair = (state_r == ST_SECOND);
    word_nxt.mode_err    = (layout_r == LAY_NONE);
    word_nxt.layout      = layout_r;
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // A receiver stall fills the two entries, then holds the sequencer
  lane_skid_buffer #(
    .W ($bits(out_word_t))
  ) u_buf (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_valid (buf_push),
    .i_data  (word_nxt),
    .o_ready (buf_ready),
    .o_valid (O_LANES_VALID),
    .o_data  (O_WORD),
    .i_ready (I_LANES_READY)
  );

endmodule

// ==== tb/jesd_lane_sample_mapper_props.sv ====
// Port-level checker for the lane sample mapper
`timescale 1ns/1ps
module jesd_lane_sample_mapper_props
  import lane_map_pkg::*;
(
  input wire logic      I_CORE_CLK,
  input wire logic      I_RST_N,
  input wire logic      I_IN_VALID,
  input wire in_frame_t I_FRAME,
  input wire logic      O_IN_READY,
  input wire logic      O_LANES_VALID,
  input wire out_word_t O_WORD,
  input wire logic      I_LANES_READY
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_take_idle;
    I_IN_VALID && O_IN_READY && !O_LANES_VALID;
  endsequence
  sequence s_word_out;
    !O_LANES_VALID ##1 O_LANES_VALID;
  endsequence
  sequence s_first_half;
    O_LANES_VALID && I_LANES_READY && O_WORD.layout == LAY_D8_2 && !O_WORD.second_pair;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_latency;
    s_take_idle |=> s_word_out;
  endproperty
  property p_hold;
    O_LANES_VALID && !I_LANES_READY |=> O_LANES_VALID && $stable(O_WORD);
  endproperty
  property p_ready_drop;
    I_IN_VALID && O_IN_READY |=> !O_IN_READY;
  endproperty
  property p_err_zero;
    O_LANES_VALID && O_WORD.mode_err |-> O_WORD.lanes == '0;
  endproperty
  property p_pair;
    s_first_half |=> ##[0:4] (O_LANES_VALID && O_WORD.second_pair);
  endproperty
  property p_two_zero;
    O_LANES_VALID && O_WORD.layout == LAY_D8_2
      |-> O_WORD.lanes.lane_a[7:1] == '0 && O_WORD.lanes.lane_b[7:1] == '0;
  endproperty
  property p_four_zero;
    O_LANES_VALID && O_WORD.layout == LAY_D8_4
      |-> O_WORD.lanes.lane_a[7:2] == '0 && O_WORD.lanes.lane_b[7:2] == '0;
  endproperty
  property p_eight_zero;
    O_LANES_VALID && (O_WORD.layout == LAY_D4_8 || O_WORD.layout == LAY_D8_8)
      |-> O_WORD.lanes.lane_a[7:4] == '0 && O_WORD.lanes.lane_b[7:4] == '0;
  endproperty
  property p_byp_zero;
    O_LANES_VALID && O_WORD.layout == LAY_BYP12
      |-> O_WORD.lanes.lane_a[7:6] == '0 && O_WORD.lanes.lane_b[7:6] == '0;
  endproperty

  a_latency:    assert property (p_latency) else $error("word late after take");
  a_hold:       assert property (p_hold) else $error("word changed under stall");
  a_ready_drop: assert property (p_ready_drop) else $error("ready held after take");
  a_err_zero:   assert property (p_err_zero) else $error("lanes not zero on bad mode");
  a_pair:       assert property (p_pair) else $error("second half missing");
  a_two_zero:   assert property (p_two_zero) else $error("two-lane spill");
  a_four_zero:  assert property (p_four_zero) else $error("four-lane spill");
  a_eight_zero: assert property (p_eight_zero) else $error("eight-lane spill");
  a_byp_zero:   assert property (p_byp_zero) else $error("bypass lane spill");
endmodule

// ==== tb/lane_rx_model.sv ====
// Receiver-side model: ready pattern and sample rebuild
`timescale 1ns/1ps
module lane_rx_model
  import lane_map_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  // Lane words in
  input  wire logic      i_stall,
  input  wire logic      i_valid,
  input  wire out_word_t i_word,
  output logic           o_ready,
  // Rebuilt sample
  output samp15_t        o_a_inphase0
);
  logic [1:0] cnt_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end

  // Ready one cycle in four under stall, so the buffer fills
  assign o_ready = !i_stall || (cnt_r == 2'h3);

  // undo placement of channel A sample 0, packed or flagged
  always_ff @(posedge i_clk)
  begin
    if (i_valid && o_ready && !i_word.mode_err && !i_word.second_pair)
    begin
      if (i_word.layout == LAY_BYP12) o_a_inphase0 <= {3'h0, i_word.lanes.lane_a[0][15:4]};
      else o_a_inphase0 <= i_word.lanes.lane_a[0][15:1];
    end
  end
endmodule

// ==== tb/jesd_lane_sample_mapper_test.sv ====
// Self-checking bench for the lane sample mapper
`timescale 1ns/1ps
module jesd_lane_sample_mapper_test;
  import lane_map_pkg::*;
  logic      core_clk = 1'b0;
  logic      rst_n = 1'b0;
  logic      in_valid = 1'b0;
  in_frame_t frame = '0;
  logic      in_ready;
  logic      lanes_valid;
  out_word_t word;
  logic      lanes_ready;
  logic      stall = 1'b0;
  int        error_cnt = 0;
  int        samples_checked = 0;
  out_word_t exp_q[$];
  samp15_t   rx_samp;
  samp15_t   exp_s[$];

  always #5 core_clk = ~core_clk;

  jesd_lane_sample_mapper i_jesd_lane_sample_mapper (.I_CORE_CLK(core_clk), .I_RST_N(rst_n),
    .I_IN_VALID(in_valid), .I_FRAME(frame), .O_IN_READY(in_ready),
    .O_LANES_VALID(lanes_valid), .O_WORD(word), .I_LANES_READY(lanes_ready));
  lane_rx_model i_lane_rx_model (.i_clk(core_clk), .i_rst_n(rst_n), .i_stall(stall),
    .i_valid(lanes_valid), .i_word(word), .o_ready(lanes_ready), .o_a_inphase0(rx_samp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [$bits(out_word_t)-1:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic lane_word_t lw(chan_frame_t c, int k, bit q);
    return q ? {c.quad[k], c.quad_flag[k]} : {c.inphase[k], c.inphase_flag[k]};
  endfunction

  // Lanes per channel n: 0 bypass, 1 two-lane halves, else I block then Q block
  function automatic lanes_t exp_lanes(in_frame_t f, int n, bit sec);
    lanes_t      e;
    logic [47:0] ta;
    logic [47:0] tb;
    e = '0;
    if (n == 0)
    begin
      for (int g = 0; g < 2; g++)
      begin
        ta = {f.bypass[8*g], f.bypass[8*g+2], f.bypass[8*g+4], f.bypass[8*g+6]};
        tb = {f.bypass[8*g+1], f.bypass[8*g+3], f.bypass[8*g+5], f.bypass[8*g+7]};
        for (int j = 0; j < 3; j++)
        begin
          e.lane_a[3*g+j] = ta[47-16*j -: 16];
          e.lane_b[3*g+j] = tb[47-16*j -: 16];
        end
      end
    end
    else if (n == 1)
    begin
      e.lane_a[0] = lw(f.chan_a, 0, sec);
      e.lane_b[0] = lw(f.chan_b, 0, sec);
    end
    else
      for (int k = 0; k < n; k++)
      begin
        e.lane_a[k] = lw(f.chan_a, k % (n / 2), k >= n / 2);
        e.lane_b[k] = lw(f.chan_b, k % (n / 2), k >= n / 2);
      end
    return e;
  endfunction

  task automatic timeout_fail;
    error_cnt++;
    $display("CHECK FAILED handshake exp 1 seen 0");
    tally_and_finish();
  endtask

  // Offer one frame; n < 0 marks an unknown mode
  task automatic send(logic [MODE_W-1:0] m, int n);
    in_frame_t f;
    out_word_t e;
    int        i;
    f = '0;
    f.link_mode_number = m;
    for (i = 0; i < 4; i++)
    begin
      f.chan_a.inphase[i] = 15'(16'h1230 + 16'h1111 * i + m);
      f.chan_a.quad[i] = 15'(16'h4561 + 16'h0707 * i);
      f.chan_b.inphase[i] = 15'(16'h2342 + 16'h0b0b * i);
      f.chan_b.quad[i] = 15'(16'h5673 + 16'h0303 * i);
    end
    f.chan_a.inphase_flag = 4'h5;
    f.chan_a.quad_flag = 4'ha;
    f.chan_b.inphase_flag = 4'h3;
    f.chan_b.quad_flag = 4'hc;
    for (i = 0; i < 16; i++) f.bypass[i] = 12'(12'h0a5 + 12'h111 * i + m);
    e = '0;
    e.mode_err = (n < 0);
    case (n)
      0: e.layout = LAY_BYP12;
      1: e.layout = LAY_D8_2;
      2: e.layout = LAY_D8_4;
      4: e.layout = (m == MODE_11 || m == MODE_47) ? LAY_D4_8 : LAY_D8_8;
      8: e.layout = (m == MODE_12 || m == MODE_53) ? LAY_D4_16 : LAY_D8_16;
      default: e.layout = LAY_NONE;
    endcase
    if (n >= 0) e.lanes = exp_lanes(f, n, 1'b0);
    if (n > 0) exp_s.push_back(f.chan_a.inphase[0]);
    else if (n == 0) exp_s.push_back(15'(f.bypass[0]));
    exp_q.push_back(e);
    if (n == 1)
    begin
      e.lanes = exp_lanes(f, 1, 1'b1);
      e.second_pair = 1'b1;
      exp_q.push_back(e);
    end
    @(negedge core_clk);
    frame = f;
    in_valid = 1'b1;
    i = 0;
    while (!in_ready && i < 60)
    begin
      @(negedge core_clk);
      i++;
    end
    if (i == 60) timeout_fail();
    @(negedge core_clk);
    in_valid = 1'b0;
  endtask

  task automatic drain(int cnt);
    out_word_t w;
    out_word_t e;
    int        i;
    for (int k = 0; k < cnt; k++)
    begin
      i = 0;
      while (!(lanes_valid && lanes_ready) && i < 200)
      begin
        @(negedge core_clk);
        i++;
      end
      if (i == 200) timeout_fail();
      w = word;
      e = exp_q.pop_front();
      chk("lane word", w, e);
      @(negedge core_clk);
      if (!e.mode_err && !e.second_pair)
        chk("rebuilt sample", rx_samp, exp_s.pop_front());
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_dec4;
    fork
      begin
        send(MODE_11, 4);
        send(MODE_47, 4);
        send(MODE_12, 8);
        send(MODE_53, 8);
      end
      drain(4);
    join
  endtask

  task automatic t_dec8_stalled;
    stall = 1'b1;
    fork
      begin
        send(MODE_13, 1);
        send(MODE_39, 1);
        send(MODE_56, 1);
        send(MODE_59, 1);
        send(MODE_66, 1);
        send(MODE_68, 1);
        send(MODE_14, 2);
        send(MODE_49, 2);
        send(MODE_57, 2);
        send(MODE_60, 2);
        send(MODE_67, 2);
        send(MODE_15, 4);
        send(MODE_55, 4);
        send(MODE_58, 4);
        send(MODE_16, 8);
      end
      drain(21);
    join
    stall = 1'b0;
  endtask

  task automatic t_bypass_and_bad;
    stall = 1'b1;
    fork
      begin
        send(MODE_19, 0);
        send(MODE_42, 0);
        send(7'h00, -1);
        send(7'h7f, -1);
      end
      drain(4);
    join
    stall = 1'b0;
  endtask

  initial
  begin
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    chk("ready at release", in_ready, 1'b0);
    chk("valid at release", lanes_valid, 1'b0);
    t_dec4();
    t_dec8_stalled();
    t_bypass_and_bad();
    tally_and_finish();
  end
endmodule

bind jesd_lane_sample_mapper jesd_lane_sample_mapper_props i_jesd_lane_sample_mapper_props (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_IN_VALID(I_IN_VALID), .I_FRAME(I_FRAME),
  .O_IN_READY(O_IN_READY), .O_LANES_VALID(O_LANES_VALID), .O_WORD(O_WORD),
  .I_LANES_READY(I_LANES_READY));
